// [rtl/mfc_pkg.sv]
package mfc_pkg;
   localparam logic [7:0]  FUNC_WRITE_MULTI = 8'h10;
   localparam logic [7:0]  CHAR_COLON       = 8'h3a;
   localparam logic [7:0]  CHAR_CR          = 8'h0d;
   localparam logic [7:0]  CHAR_LF          = 8'h0a;
   localparam logic [7:0]  BROADCAST_ADDR   = 8'h00;
   localparam logic [15:0] CRC_PRESET       = 16'hffff;
   localparam logic [15:0] CRC_POLY         = 16'ha001;
   localparam logic [15:0] CRC_RESIDUE      = 16'h0000;
   localparam logic [7:0]  LRC_RESIDUE      = 8'h00;
   localparam int          BUF_DEPTH        = 64;
   localparam logic [6:0]  BUF_FULL         = 7'h40;
   localparam logic [5:0]  ADDR_POS         = 6'h00;
   localparam logic [5:0]  FUNC_POS         = 6'h01;
   localparam logic [5:0]  START_HI_POS     = 6'h02;
   localparam logic [5:0]  START_LO_POS     = 6'h03;
   localparam logic [5:0]  COUNT_HI_POS     = 6'h04;
   localparam logic [5:0]  COUNT_LO_POS     = 6'h05;
   localparam logic [5:0]  BYTE_CNT_POS     = 6'h06;
   localparam logic [6:0]  HDR_LEN          = 7'h07;
   localparam logic [6:0]  RESP_LEN         = 7'h06;
   localparam logic [6:0]  ASCII_CHK_LEN    = 7'h01;
   localparam logic [6:0]  RTU_CHK_LEN      = 7'h02;
   localparam logic [6:0]  ASCII_LRC_HI_POS = 7'h0d;
   localparam logic [6:0]  ASCII_LRC_LO_POS = 7'h0e;
   localparam logic [6:0]  ASCII_CR_POS     = 7'h0f;
   localparam logic [6:0]  ASCII_TX_LAST    = 7'h10;
   localparam logic [6:0]  RTU_CRC_LO_POS   = 7'h06;
   localparam logic [6:0]  RTU_TX_LAST      = 7'h07;
   localparam int          GAP_TIME_MS      = 10;
   localparam int          CLK_PERIOD_NS    = 50;
   // strictly longer than the gap, hence one cycle more
   localparam int          GAP_CYCLES       =
      GAP_TIME_MS * 1000000 / CLK_PERIOD_NS + 1;

   typedef enum logic [2:0] {
      ST_HUNT,
      ST_RX,
      ST_LF,
      ST_CHECK,
      ST_WRITE,
      ST_TX
   } mfc_state_t;
endpackage

// [rtl/mfc_crc_byte.sv]
`timescale 1ns/100ps
module mfc_crc_byte (
   input  wire logic [15:0] crc_in,
   input  wire logic [7:0]  byte_in,
   output logic      [15:0] crc_out
);
   import mfc_pkg::*;

   logic [15:0] stage [9];

   assign stage[0] = crc_in ^ {8'h00, byte_in};

   // fully unrolled so a whole byte folds in one clock
   genvar i;
   generate
      for (i = 0; i < 8; i++) begin : g_shift
         assign stage[i+1] = stage[i][0] ?
            ((stage[i] >> 1) ^ CRC_POLY) : (stage[i] >> 1);
      end
   endgenerate

   assign crc_out = stage[8];
endmodule // mfc_crc_byte

// [rtl/mfc_frame_unit.sv]
`timescale 1ns/100ps
module mfc_frame_unit #(
   parameter int GAP_CYCLES = mfc_pkg::GAP_CYCLES
) (
   input  wire logic        clk_in,
   input  wire logic        reset_in,
   input  wire logic        ce_in,
   input  wire logic        ascii_mode_in,
   input  wire logic [7:0]  station_addr_in,
   input  wire logic        rx_valid_in,
   input  wire logic [7:0]  rx_byte_in,
   input  wire logic        tx_ready_in,
   output logic             tx_valid_out,
   output logic      [7:0]  tx_byte_out,
   output logic             cmd_valid_out,
   output logic      [15:0] start_addr_out,
   output logic      [15:0] word_count_out,
   output logic             word_valid_out,
   output logic      [15:0] word_out,
   output logic             frame_error_out,
   output logic             check_error_out
);
   import mfc_pkg::*;

   function automatic logic [7:0] hex_char(input logic [3:0] n);
      return (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
   endfunction

   mfc_state_t  state,    next_state;
   logic [6:0]  wr_idx,   next_wr_idx;
   logic [6:0]  pos,      next_pos;
   logic [3:0]  hi_nib,   next_hi_nib;
   logic        hi_phase, next_hi_phase;
   logic [7:0]  lrc,      next_lrc;
   logic [15:0] crc,      next_crc;
   logic [31:0] idle_cnt, next_idle_cnt;
   logic        next_tx_valid, next_cmd_valid, next_word_valid;
   logic        next_frame_error, next_check_error;
   logic [7:0]  next_tx_byte;
   logic [15:0] next_start_addr, next_word_count, next_word;
   logic [7:0]  buf_mem [BUF_DEPTH];
   logic        wr_en, byte_done, hex_ok, gap_seen, chk_ok, addressed;
   logic        shape_ok;
   logic [7:0]  byte_val, crc_byte, lrc_chk, resp_byte;
   logic [3:0]  rx_nib;
   logic [15:0] crc_next;
   logic [8:0]  exp_len;
   logic [5:0]  rd_addr;

   mfc_crc_byte u_crc (
      .crc_in  (crc),
      .byte_in (crc_byte),
      .crc_out (crc_next)
   );

   always_comb begin
      hex_ok = 1'b1;
      rx_nib = 4'h0;
      if (rx_byte_in >= 8'h30 && rx_byte_in <= 8'h39) begin
         rx_nib = rx_byte_in[3:0];
      end else if (rx_byte_in >= 8'h41 && rx_byte_in <= 8'h46) begin
         rx_nib = 4'(rx_byte_in[3:0] + 4'h9);
      end else begin
         hex_ok = 1'b0;
      end
   end

   // the reply echoes the first six command bytes, so the buffer serves it
   assign rd_addr   = 6'(7'(pos - 7'h01) >> 1);
   assign resp_byte = buf_mem[ascii_mode_in ? rd_addr : pos[5:0]];
   assign lrc_chk   = 8'(~lrc + 8'h01);
   // kept out of the next-state process so the check path has no loop
   assign byte_val  = ascii_mode_in ? {hi_nib, rx_nib} : rx_byte_in;
   assign crc_byte  = (state == ST_TX) ? tx_byte_out : byte_val;
   assign gap_seen  = (idle_cnt >= 32'(GAP_CYCLES));
   // running the check over the received check leaves a fixed residue
   assign chk_ok    = ascii_mode_in ? (lrc == LRC_RESIDUE)
                                    : (crc == CRC_RESIDUE);
   assign addressed = (buf_mem[ADDR_POS] == station_addr_in) ||
                      (buf_mem[ADDR_POS] == BROADCAST_ADDR);
   assign exp_len   = {2'b00, HDR_LEN} + {1'b0, buf_mem[BYTE_CNT_POS]} +
                      {2'b00, ascii_mode_in ? ASCII_CHK_LEN : RTU_CHK_LEN};
   assign shape_ok  = ({2'b00, wr_idx} == exp_len) &&
                      (buf_mem[COUNT_HI_POS] == 8'h00) &&
                      (buf_mem[BYTE_CNT_POS] ==
                       {buf_mem[COUNT_LO_POS][6:0], 1'b0}) &&
                      (buf_mem[COUNT_LO_POS][7] == 1'b0);

   always_comb begin
      next_state       = state;
      next_wr_idx      = wr_idx;
      next_pos         = pos;
      next_hi_nib      = hi_nib;
      next_hi_phase    = hi_phase;
      next_lrc         = lrc;
      next_crc         = crc;
      next_tx_valid    = tx_valid_out;
      next_tx_byte     = tx_byte_out;
      next_start_addr  = start_addr_out;
      next_word_count  = word_count_out;
      next_word        = word_out;
      next_cmd_valid   = 1'b0;
      next_word_valid  = 1'b0;
      next_frame_error = 1'b0;
      next_check_error = 1'b0;
      wr_en            = 1'b0;
      byte_done        = 1'b0;
      next_idle_cnt    = rx_valid_in ? 32'h0000_0000 :
                         (gap_seen ? idle_cnt : 32'(idle_cnt + 32'h1));
      case (state)
         ST_HUNT: begin
            if (rx_valid_in) begin
               if (ascii_mode_in) begin
                  if (rx_byte_in == CHAR_COLON) begin
                     next_state = ST_RX;
                  end
               end else if (gap_seen) begin
                  next_state = ST_RX;
                  byte_done  = 1'b1;
               end
            end
         end
         ST_RX: begin
            if (!ascii_mode_in) begin
               byte_done = rx_valid_in;
               if (!rx_valid_in && gap_seen) begin
                  next_state = ST_CHECK;
               end
            end else if (rx_valid_in) begin
               if (rx_byte_in == CHAR_COLON) begin
                  // a fresh colon restarts the frame, dropping the partial
                  next_wr_idx   = 7'h00;
                  next_hi_phase = 1'b0;
                  next_lrc      = 8'h00;
                  next_crc      = CRC_PRESET;
               end else if (rx_byte_in == CHAR_CR) begin
                  next_state = hi_phase ? ST_HUNT : ST_LF;
                  next_frame_error = hi_phase;
               end else if (hex_ok) begin
                  next_hi_phase = !hi_phase;
                  next_hi_nib   = rx_nib;
                  byte_done     = hi_phase;
               end else begin
                  next_state       = ST_HUNT;
                  next_frame_error = 1'b1;
               end
            end
         end
         ST_LF: begin
            if (rx_valid_in) begin
               next_state       = (rx_byte_in == CHAR_LF) ? ST_CHECK
                                                          : ST_HUNT;
               next_frame_error = (rx_byte_in != CHAR_LF);
            end
         end
         ST_CHECK: begin
            next_state = ST_HUNT;
            if (!chk_ok) begin
               next_check_error = 1'b1;
            end else if (addressed &&
                         buf_mem[FUNC_POS] == FUNC_WRITE_MULTI) begin
               if (shape_ok) begin
                  next_state      = ST_WRITE;
                  next_cmd_valid  = 1'b1;
                  next_start_addr = {buf_mem[START_HI_POS],
                                     buf_mem[START_LO_POS]};
                  next_word_count = {buf_mem[COUNT_HI_POS],
                                     buf_mem[COUNT_LO_POS]};
                  next_pos        = 7'h00;
               end else begin
                  next_frame_error = 1'b1;
               end
            end
         end
         ST_WRITE: begin
            if ({1'b0, pos} < buf_mem[BYTE_CNT_POS]) begin
               next_word_valid = 1'b1;
               next_word = {buf_mem[6'(HDR_LEN + pos)],
                            buf_mem[6'(HDR_LEN + pos + 7'h01)]};
               next_pos  = 7'(pos + 7'h02);
            end else begin
               next_pos   = 7'h00;
               next_lrc   = 8'h00;
               next_crc   = CRC_PRESET;
               next_state = (buf_mem[ADDR_POS] == BROADCAST_ADDR) ?
                            ST_HUNT : ST_TX;
            end
         end
         ST_TX: begin
            if (!tx_valid_out) begin
               next_tx_valid = 1'b1;
               if (!ascii_mode_in) begin
                  next_tx_byte = (pos < RTU_CRC_LO_POS) ? resp_byte :
                                 (pos == RTU_CRC_LO_POS) ? crc[7:0]
                                                         : crc[15:8];
               end else if (pos == 7'h00) begin
                  next_tx_byte = CHAR_COLON;
               end else if (pos < ASCII_LRC_HI_POS) begin
                  next_tx_byte = hex_char(pos[0] ? resp_byte[7:4]
                                                 : resp_byte[3:0]);
               end else if (pos == ASCII_LRC_HI_POS) begin
                  next_tx_byte = hex_char(lrc_chk[7:4]);
               end else if (pos == ASCII_LRC_LO_POS) begin
                  next_tx_byte = hex_char(lrc_chk[3:0]);
               end else begin
                  next_tx_byte = (pos == ASCII_CR_POS) ? CHAR_CR : CHAR_LF;
               end
            end else if (tx_ready_in) begin
               next_tx_valid = 1'b0;
               next_pos      = 7'(pos + 7'h01);
               if (ascii_mode_in && !pos[0] && pos != 7'h00 &&
                   pos < ASCII_LRC_HI_POS) begin
                  next_lrc = 8'(lrc + resp_byte);
               end
               if (!ascii_mode_in && pos < RESP_LEN) begin
                  next_crc = crc_next;
               end
               if (pos == (ascii_mode_in ? ASCII_TX_LAST : RTU_TX_LAST)) begin
                  next_state = ST_HUNT;
               end
            end
         end
         default: next_state = ST_HUNT;
      endcase
      if (byte_done) begin
         if (wr_idx == BUF_FULL) begin
            // buffer full at 64 bytes, though a longer frame can pass the shape check: drop rather than wrap
            next_state       = ST_HUNT;
            next_frame_error = 1'b1;
         end else begin
            wr_en       = 1'b1;
            next_wr_idx = 7'(wr_idx + 7'h01);
            next_lrc    = 8'(lrc + byte_val);
            next_crc    = crc_next;
         end
      end
      if (next_state == ST_HUNT) begin
         next_wr_idx   = 7'h00;
         next_hi_phase = 1'b0;
         next_lrc      = 8'h00;
         next_crc      = CRC_PRESET;
         next_pos      = 7'h00;
         next_tx_valid = 1'b0;
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         state           <= ST_HUNT;
         wr_idx          <= 7'h00;
         pos             <= 7'h00;
         hi_nib          <= 4'h0;
         hi_phase        <= 1'b0;
         lrc             <= 8'h00;
         crc             <= CRC_PRESET;
         idle_cnt        <= 32'h0000_0000;
         tx_valid_out    <= 1'b0;
         tx_byte_out     <= 8'h00;
         cmd_valid_out   <= 1'b0;
         start_addr_out  <= 16'h0000;
         word_count_out  <= 16'h0000;
         word_valid_out  <= 1'b0;
         word_out        <= 16'h0000;
         frame_error_out <= 1'b0;
         check_error_out <= 1'b0;
      end else if (ce_in) begin
         state           <= next_state;
         wr_idx          <= next_wr_idx;
         pos             <= next_pos;
         hi_nib          <= next_hi_nib;
         hi_phase        <= next_hi_phase;
         lrc             <= next_lrc;
         crc             <= next_crc;
         idle_cnt        <= next_idle_cnt;
         tx_valid_out    <= next_tx_valid;
         tx_byte_out     <= next_tx_byte;
         cmd_valid_out   <= next_cmd_valid;
         start_addr_out  <= next_start_addr;
         word_count_out  <= next_word_count;
         word_valid_out  <= next_word_valid;
         word_out        <= next_word;
         frame_error_out <= next_frame_error;
         check_error_out <= next_check_error;
      end
   end

   // the buffer has no reset; every frame overwrites what it reads
   always_ff @(posedge clk_in) begin
      if (ce_in && wr_en) begin
         buf_mem[wr_idx[5:0]] <= byte_val;
      end
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);

   property p_colon_opens;
      ce_in && state == ST_HUNT && ascii_mode_in && rx_valid_in &&
      rx_byte_in == CHAR_COLON |=> state == ST_RX;
   endproperty
   a_colon_opens: assert property (p_colon_opens)
      else $error("colon did not open an ascii frame");

   property p_reply_colon;
      $rose(tx_valid_out) && ascii_mode_in && pos == 7'h00
      |-> tx_byte_out == CHAR_COLON;
   endproperty
   a_reply_colon: assert property (p_reply_colon)
      else $error("ascii reply does not start with a colon");

   property p_crc_preset;
      state == ST_HUNT |-> crc == CRC_PRESET && lrc == 8'h00;
   endproperty
   a_crc_preset: assert property (p_crc_preset)
      else $error("check register not preset while hunting");

   property p_no_broadcast_reply;
      tx_valid_out |-> buf_mem[ADDR_POS] != BROADCAST_ADDR;
   endproperty
   a_no_broadcast_reply: assert property (p_no_broadcast_reply)
      else $error("reply sent to a broadcast");

   property p_bad_check_drop;
      ce_in && state == ST_CHECK && !chk_ok
      |=> state == ST_HUNT && check_error_out && !cmd_valid_out;
   endproperty
   a_bad_check_drop: assert property (p_bad_check_drop)
      else $error("frame with bad check was not dropped");

   property p_crc_low_first;
      tx_valid_out && !ascii_mode_in && pos == RTU_CRC_LO_POS
      |-> tx_byte_out == crc[7:0];
   endproperty
   a_crc_low_first: assert property (p_crc_low_first)
      else $error("rtu check low byte not sent first");

   property p_lrc_high_nibble;
      tx_valid_out && ascii_mode_in && pos == ASCII_LRC_HI_POS
      |-> tx_byte_out == hex_char(lrc_chk[7:4]);
   endproperty
   a_lrc_high_nibble: assert property (p_lrc_high_nibble)
      else $error("ascii check high nibble wrong");

   property p_bad_char;
      ce_in && state == ST_RX && ascii_mode_in && rx_valid_in && !hex_ok &&
      rx_byte_in != CHAR_COLON && rx_byte_in != CHAR_CR
      |=> frame_error_out && state == ST_HUNT;
   endproperty
   a_bad_char: assert property (p_bad_char)
      else $error("non-hex character not flagged");

   c_ascii_reply: cover property (ascii_mode_in && tx_valid_out &&
                                  tx_byte_out == CHAR_LF);
   c_rtu_reply: cover property (!ascii_mode_in && tx_valid_out &&
                                pos == RTU_TX_LAST);
   c_broadcast: cover property (cmd_valid_out &&
                                buf_mem[ADDR_POS] == BROADCAST_ADDR);
endmodule // mfc_frame_unit

// [verif/mfc_master_model.sv]
`timescale 1ns/100ps
module mfc_master_model
   import mfc_pkg::*;
#(
   parameter int GAP_CYCLES = 20
) (
   input  wire logic       clk_in,
   input  wire logic       tx_valid_in,
   input  wire logic [7:0] tx_byte_in,
   output logic            rx_valid_out,
   output logic      [7:0] rx_byte_out,
   output logic            tx_ready_out
);
   logic [7:0] body_q[$];
   logic [7:0] frame_q[$];
   logic [7:0] got_q[$];
   logic       slow;
   logic [1:0] pace;

   initial begin
      rx_valid_out = 1'b0;
      rx_byte_out  = 8'h00;
      tx_ready_out = 1'b0;
      slow         = 1'b0;
      pace         = 2'h0;
   end

   function automatic logic [7:0] hex_char(input logic [3:0] n);
      return (n < 4'ha) ? {4'h3, n} : 8'h37 + {4'h0, n};
   endfunction

   task automatic push_hex(input logic [7:0] b);
      frame_q.push_back(hex_char(b[7:4]));
      frame_q.push_back(hex_char(b[3:0]));
   endtask

   // spoil flips bits of the check so a scenario can corrupt it on purpose
   task automatic make_frame(input logic ascii, input logic [7:0] spoil);
      logic [7:0]  sum;
      logic [15:0] crc;
      sum = 8'h00;
      crc = CRC_PRESET;
      frame_q = {};
      foreach (body_q[i]) begin
         sum = sum + body_q[i];
         crc = crc ^ {8'h00, body_q[i]};
         for (int k = 0; k < 8; k++) begin
            crc = crc[0] ? (crc >> 1) ^ CRC_POLY : crc >> 1;
         end
      end
      if (ascii) begin
         sum = (8'h00 - sum) ^ spoil;
         frame_q.push_back(CHAR_COLON);
         foreach (body_q[i]) push_hex(body_q[i]);
         push_hex(sum);
         frame_q.push_back(CHAR_CR);
         frame_q.push_back(CHAR_LF);
      end else begin
         crc = crc ^ {8'h00, spoil};
         frame_q = body_q;
         frame_q.push_back(crc[7:0]);
         frame_q.push_back(crc[15:8]);
      end
   endtask

   // a released data line shows the inverse of its last byte
   task automatic send_frame(input logic ascii, input logic [7:0] spoil,
                             input int bad_pos);
      make_frame(ascii, spoil);
      got_q = {};
      if (!ascii) repeat (GAP_CYCLES + 4) @(negedge clk_in);
      foreach (frame_q[i]) begin
         @(negedge clk_in);
         rx_valid_out = 1'b1;
         rx_byte_out  = (i == bad_pos) ? 8'h61 : frame_q[i];
         @(negedge clk_in);
         rx_valid_out = 1'b0;
         rx_byte_out  = ~rx_byte_out;
      end
   endtask

   // slow sink takes one byte in four cycles at most
   always @(negedge clk_in) begin
      pace         <= pace + 2'h1;
      tx_ready_out <= !slow || pace == 2'h3;
   end

   always @(posedge clk_in) begin
      if (tx_valid_in === 1'b1 && tx_ready_out === 1'b1) begin
         got_q.push_back(tx_byte_in);
      end
   end
endmodule // mfc_master_model

// [verif/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
   import mfc_pkg::*;
   localparam int GAP = 20;
   logic        clk_in;
   logic        reset_in;
   logic        ce_in;
   logic        ascii_mode_in;
   logic [7:0]  station_addr_in;
   logic        rx_valid;
   logic [7:0]  rx_byte;
   logic        tx_ready;
   logic        tx_valid;
   logic [7:0]  tx_byte;
   logic        cmd_valid_out;
   logic [15:0] start_addr_out;
   logic [15:0] word_count_out;
   logic        word_valid_out;
   logic [15:0] word_out;
   logic        frame_error_out;
   logic        check_error_out;
   logic [15:0] words_q[$];
   int          err_total;
   int          check_count;
   int          cycles;
   int          cmd_n;
   int          ferr_n;
   int          cerr_n;

   mfc_frame_unit #(.GAP_CYCLES(GAP)) u_mfc_frame_unit (
      .clk_in(clk_in), .reset_in(reset_in), .ce_in(ce_in),
      .ascii_mode_in(ascii_mode_in), .station_addr_in(station_addr_in),
      .rx_valid_in(rx_valid), .rx_byte_in(rx_byte),
      .tx_ready_in(tx_ready), .tx_valid_out(tx_valid),
      .tx_byte_out(tx_byte), .cmd_valid_out(cmd_valid_out),
      .start_addr_out(start_addr_out), .word_count_out(word_count_out),
      .word_valid_out(word_valid_out), .word_out(word_out),
      .frame_error_out(frame_error_out), .check_error_out(check_error_out));

   mfc_master_model #(.GAP_CYCLES(GAP)) u_master (
      .clk_in(clk_in), .tx_valid_in(tx_valid), .tx_byte_in(tx_byte),
      .rx_valid_out(rx_valid), .rx_byte_out(rx_byte),
      .tx_ready_out(tx_ready));

   always #25 clk_in = ~clk_in;

   always @(posedge clk_in) begin
      cycles++;
      if (cmd_valid_out === 1'b1) cmd_n++;
      if (frame_error_out === 1'b1) ferr_n++;
      if (check_error_out === 1'b1) cerr_n++;
      if (word_valid_out === 1'b1) words_q.push_back(word_out);
      if (cycles == 20000) begin
         err_total++;
         test_done();
      end
   end

   task automatic test_done;
      if (err_total == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic set_cmd(input logic [7:0] addr);
      u_master.body_q = '{addr, FUNC_WRITE_MULTI, 8'h05, 8'h00, 8'h00,
                          8'h02, 8'h04, 8'h13, 8'h88, 8'h0f, 8'ha0};
   endtask

   // waits for the whole reply, or a quiet window when none is due
   task automatic run(input logic ascii, input logic [7:0] spoil,
                      input int bad_pos, input int n_reply);
      int lim;
      cmd_n = 0;
      ferr_n = 0;
      cerr_n = 0;
      words_q = {};
      @(negedge clk_in);
      ascii_mode_in = ascii;
      u_master.send_frame(ascii, spoil, bad_pos);
      lim = 0;
      while (lim < GAP + 300 &&
             !(n_reply > 0 && u_master.got_q.size() >= n_reply)) begin
         @(negedge clk_in);
         lim++;
      end
      repeat (8) @(negedge clk_in);
      cmp16(16'(u_master.got_q.size()), 16'(n_reply));
   endtask

   task automatic chk_reply(input logic [7:0] addr, input logic ascii);
      u_master.body_q = '{addr, FUNC_WRITE_MULTI, 8'h05, 8'h00, 8'h00, 8'h02};
      u_master.make_frame(ascii, 8'h00);
      for (int i = 0; i < u_master.frame_q.size(); i++) begin
         cmp8(u_master.got_q[i], u_master.frame_q[i]);
      end
   endtask

   task automatic t_write(input logic ascii, input logic slow);
      set_cmd(8'h01);
      u_master.slow = slow;
      run(ascii, 8'h00, -1, ascii ? 17 : 8);
      cmp16(16'(cmd_n), 16'h0001);
      cmp16(16'(ferr_n + cerr_n), 16'h0000);
      cmp16(start_addr_out, 16'h0500);
      cmp16(word_count_out, 16'h0002);
      cmp16(words_q[0], 16'h1388);
      cmp16(words_q[1], 16'h0fa0);
      chk_reply(8'h01, ascii);
      if (ascii) begin
         cmp8(u_master.got_q[13], 8'h45);
         cmp8(u_master.got_q[14], 8'h38);
         cmp8(u_master.got_q[16], CHAR_LF);
      end else begin
         cmp8(u_master.got_q[6], 8'h41);
         cmp8(u_master.got_q[7], 8'h04);
      end
      u_master.slow = 1'b0;
   endtask

   task automatic t_broadcast;
      set_cmd(BROADCAST_ADDR);
      run(1'b1, 8'h00, -1, 0);
      cmp16(16'(cmd_n), 16'h0001);
      cmp16(16'(words_q.size()), 16'h0002);
   endtask

   task automatic t_bad_check(input logic ascii);
      set_cmd(8'h01);
      run(ascii, 8'h01, -1, 0);
      cmp16(16'(cerr_n), 16'h0001);
      cmp16(16'(cmd_n), 16'h0000);
   endtask

   task automatic t_bad_char;
      set_cmd(8'h01);
      run(1'b1, 8'h00, 3, 0);
      cmp16(16'(ferr_n), 16'h0001);
      cmp16(16'(cmd_n), 16'h0000);
   endtask

   task automatic t_foreign;
      set_cmd(8'h02);
      run(1'b0, 8'h00, -1, 0);
      cmp16(16'(cmd_n + ferr_n + cerr_n), 16'h0000);
   endtask

   // the line feed is replaced by a non-hex character
   task automatic t_no_lf;
      set_cmd(8'h01);
      run(1'b1, 8'h00, 26, 0);
      cmp16(16'(ferr_n), 16'h0001);
      cmp16(16'(cmd_n), 16'h0000);
   endtask

   // byte count disagrees with word count and with the frame length
   task automatic t_bad_shape;
      u_master.body_q = '{8'h01, FUNC_WRITE_MULTI, 8'h05, 8'h00, 8'h00,
                          8'h02, 8'h06, 8'h13, 8'h88, 8'h0f, 8'ha0};
      run(1'b0, 8'h00, -1, 0);
      cmp16(16'(ferr_n), 16'h0001);
      cmp16(16'(cmd_n), 16'h0000);
   endtask

   initial begin
      clk_in = 1'b0;
      reset_in = 1'b1;
      ce_in = 1'b1;
      ascii_mode_in = 1'b1;
      station_addr_in = 8'h01;
      err_total = 0;
      check_count = 0;
      cycles = 0;
      repeat (4) @(negedge clk_in);
      reset_in = 1'b0;
      t_write(1'b1, 1'b0);
      t_write(1'b0, 1'b1);
      t_broadcast();
      t_bad_check(1'b1);
      t_bad_check(1'b0);
      t_bad_char();
      t_foreign();
      t_no_lf();
      t_bad_shape();
      test_done();
   end
endmodule // tb_top
